/* File: pkg/rtp_pkg.sv */
// Shared constants and types for the real-time trace port.
`default_nettype none
package rtp_pkg;

  // Trace slot timing: one status and data nibble per sample clock period
  localparam int CORE_CLK_PERIOD_NS   = 5;
  localparam int SAMPLE_CLK_PERIOD_NS = 125;
  localparam int SLOT_CYCLES          = SAMPLE_CLK_PERIOD_NS / CORE_CLK_PERIOD_NS;
  localparam logic [4:0] SLOT_LAST    = 5'(SLOT_CYCLES - 1);
  localparam logic [4:0] SLOT_RISE    = 5'(SLOT_CYCLES / 2);

  // Status nibble encodings
  localparam logic [3:0] ST_CONTINUE   = 4'h0;
  localparam logic [3:0] ST_BEGIN      = 4'h1;
  localparam logic [3:0] ST_USER_ENTRY = 4'h3;
  localparam logic [3:0] ST_PULSE      = 4'h4;
  localparam logic [3:0] ST_BRANCH     = 4'h5;
  localparam logic [3:0] ST_EXC_RETURN = 4'h7;
  localparam logic [3:0] ST_MARK_BASE  = 4'h8;
  localparam logic [3:0] ST_EXCEPTION  = 4'hC;
  localparam logic [3:0] ST_EMU_EXC    = 4'hD;
  localparam logic [3:0] ST_STOPPED    = 4'hE;
  localparam logic [3:0] ST_HALTED     = 4'hF;

  // Capture buffer shape
  localparam int FIFO_DEPTH = 2;
  localparam int DATA_BITS  = 32;
  localparam int ENTRY_BITS = DATA_BITS + 2;

  // Operand sizes of the debug-write instruction
  localparam logic [1:0] OP_BYTE = 2'h0;
  localparam logic [1:0] OP_WORD = 2'h1;
  localparam logic [1:0] OP_LONG = 2'h2;

  // Instruction classes offered by the core, one per trace slot
  typedef enum logic [2:0] {
    EV_PLAIN          = 3'h0,
    EV_PULSE          = 3'h1,
    EV_DEBUG_WRITE    = 3'h2,
    EV_BRANCH         = 3'h3,
    EV_VARIANT_BRANCH = 3'h4,
    EV_EXC_RETURN     = 3'h5,
    EV_USER_ENTRY     = 3'h6
  } rtp_kind_type;

  typedef struct packed {
    rtp_kind_type         kind;
    logic [1:0]           opSize;
    logic [DATA_BITS-1:0] operand;
  } rtp_event_type;

  // Byte count minus one and captured value
  typedef struct packed {
    logic [1:0]           byteCntM1;
    logic [DATA_BITS-1:0] data;
  } rtp_entry_type;

  // Multicycle processor modes
  typedef struct packed {
    logic halted;
    logic stopped;
    logic emuExc;
    logic exc;
  } rtp_mode_type;

  typedef enum logic [0:0] {
    DS_IDLE  = 1'b0,
    DS_SHIFT = 1'b1
  } rtp_data_state_type;

  // Marker code announcing a transfer of byteCntM1 + 1 bytes
  function automatic logic [3:0] markerOf(input logic [1:0] byteCntM1);
    markerOf = ST_MARK_BASE | {2'h0, byteCntM1};
  endfunction

  // Nibbles shown for a transfer of byteCntM1 + 1 bytes
  function automatic logic [3:0] nibblesOf(input logic [1:0] byteCntM1);
    nibblesOf = {1'b0, byteCntM1, 1'b0} + 4'h2;
  endfunction

endpackage
`default_nettype wire

/* File: src/rtp_trace_port.sv */
// Trace port top and its capture buffer.
//
// Notes on behaviour
// - Two 4-bit outputs: processor status nibble and debug data nibble.
// - Status follows the pipeline, changes with the sample clock, ignores bus transfers.
// - Captured values wait in a two-entry, 32-bit buffer before the data nibble.
// - Captured values leave one nibble per slot, least significant nibble first.
// - Core stalls only when buffer full and capture needed; status shows 0 meanwhile.
// - Status proceeds with later instructions while data nibble still emits a value.
// - Slots after the first of a multicycle instruction show code 0.
// - Most instructions show code 1 on their first slot.
// - Code 3 marks user-mode entry, after the causing instruction.
// - Trigger-pulse and debug-write instructions show code 4.
// - Debug write sends its operand always: code 4, size marker, then data.
// - A taken branch shows code 5.
// - Targets captured only for variant-addressing branches and exception returns, when capture enabled.
// - Target length 2, 3 or 4 bytes, marked by 9, A or B.
// - Marker 8 to B one slot before its 1 to 4 data bytes.
// - Exception return shows code 7.
// - Normal exception processing holds code C until done.
// - Emulation-mode exception processing holds code D until done.
// - Stopped state holds code E until an interrupt.
// - Halted state holds code F until restart or reset.
// - Codes 2 and 6 are never driven.
// - Trace disable forces sample clock, status and data outputs off.
// - Idle data nibble shows breakpoint status.
`timescale 1ns/1ps
`default_nettype none

module rtp_fifo #(
  parameter int WIDTH = 34,
  parameter int DEPTH = 2
) (
  input  wire logic             core_clk,
  input  wire logic             rst,
  input  wire logic             inValid,
  output logic                  inReady,
  input  wire logic [WIDTH-1:0] inData,
  output logic                  outValid,
  input  wire logic             outReady,
  output logic      [WIDTH-1:0] outData
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam logic [AW-1:0] LAST_IDX = AW'(DEPTH - 1);
  localparam logic [AW:0]   FULL_CNT = (AW + 1)'(DEPTH);

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wrPtr_q;
  logic [AW-1:0]    rdPtr_q;
  logic [AW:0]      count_q;
  logic             doPush;
  logic             doPop;

  assign inReady  = count_q != FULL_CNT;
  assign outValid = count_q != '0;
  assign outData  = mem_q[rdPtr_q];
  assign doPush   = inValid && inReady;
  assign doPop    = outValid && outReady;

  always_ff @(posedge core_clk)
  begin
    if (doPush)
    begin
      mem_q[wrPtr_q] <= inData;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      wrPtr_q <= '0;
      rdPtr_q <= '0;
      count_q <= '0;
    end
    else
    begin
      if (doPush)
      begin
        wrPtr_q <= (wrPtr_q == LAST_IDX) ? '0 : wrPtr_q + 1'b1;
      end
      if (doPop)
      begin
        rdPtr_q <= (rdPtr_q == LAST_IDX) ? '0 : rdPtr_q + 1'b1;
      end
      if (doPush && !doPop)
      begin
        count_q <= count_q + 1'b1;
      end
      else if (doPop && !doPush)
      begin
        count_q <= count_q - 1'b1;
      end
    end
  end
endmodule

module rtp_trace_port (
  input  wire logic                   core_clk,
  input  wire logic                   rst,
  input  wire logic                   traceOutputDisable,
  input  wire logic                   captureEnable,
  input  wire logic [1:0]             addrBytesSel,
  input  wire logic [3:0]             bkptStatus,
  input  wire rtp_pkg::rtp_mode_type  coreMode,
  input  wire logic                   evtValid,
  input  wire rtp_pkg::rtp_event_type evt,
  output logic                        evtTaken,
  output logic                        coreStall,
  output logic                        statusSampleClock,
  output logic [3:0]                  processorStatusNibble,
  output logic [3:0]                  debugDataNibble,
  output logic                        traceOutEnable
);
  logic [4:0]                  slotCnt_q;
  logic                        tick;
  logic                        modeBusy;
  logic                        markNow;
  logic                        userNow;
  logic                        capNeed;
  logic                        evtOk;
  logic                        stallNow;
  logic                        userPend_q;
  logic [3:0]                  statusNext;
  logic                        fifoInReady;
  logic                        fifoOutValid;
  rtp_pkg::rtp_entry_type      fifoIn;
  rtp_pkg::rtp_entry_type      fifoHead;
  rtp_pkg::rtp_data_state_type dataState_q;
  logic [rtp_pkg::DATA_BITS-1:0] shiftReg_q;
  logic [3:0]                  shiftLeft_q;

  // Slot divider; nibbles change at slot start, sampled at mid-slot rise
  assign tick = slotCnt_q == rtp_pkg::SLOT_LAST;

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      slotCnt_q <= '0;
    end
    else
    begin
      slotCnt_q <= tick ? '0 : slotCnt_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      statusSampleClock <= 1'b0;
      traceOutEnable    <= 1'b0;
    end
    else
    begin
      statusSampleClock <= !traceOutputDisable && (slotCnt_q >= rtp_pkg::SLOT_RISE);
      traceOutEnable    <= !traceOutputDisable;
    end
  end

  function automatic logic [3:0] evCode(input rtp_pkg::rtp_kind_type kind);
    case (kind)
      rtp_pkg::EV_PULSE,
      rtp_pkg::EV_DEBUG_WRITE:    evCode = rtp_pkg::ST_PULSE;
      rtp_pkg::EV_BRANCH,
      rtp_pkg::EV_VARIANT_BRANCH: evCode = rtp_pkg::ST_BRANCH;
      rtp_pkg::EV_EXC_RETURN:     evCode = rtp_pkg::ST_EXC_RETURN;
      default:                    evCode = rtp_pkg::ST_BEGIN;
    endcase
  endfunction

  // Capture decision and size
  always_comb
  begin
    capNeed          = 1'b0;
    fifoIn.data      = evt.operand;
    fifoIn.byteCntM1 = (addrBytesSel == 2'h0) ? 2'h1 : addrBytesSel;
    case (evt.kind)
      rtp_pkg::EV_VARIANT_BRANCH,
      rtp_pkg::EV_EXC_RETURN:
      begin
        capNeed = captureEnable;
      end
      rtp_pkg::EV_DEBUG_WRITE:
      begin
        capNeed = 1'b1;
        case (evt.opSize)
          rtp_pkg::OP_BYTE: fifoIn.byteCntM1 = 2'h0;
          rtp_pkg::OP_WORD: fifoIn.byteCntM1 = 2'h1;
          default:          fifoIn.byteCntM1 = 2'h3;
        endcase
      end
      default:
      begin
        capNeed = 1'b0;
      end
    endcase
  end

  // Marker may take the slot when the shifter frees up next slot
  assign modeBusy = |coreMode;
  assign markNow  = !modeBusy && fifoOutValid && (shiftLeft_q <= 4'h1);
  assign userNow  = !modeBusy && !markNow && userPend_q;
  assign evtOk    = evtValid && !modeBusy && !markNow && !userNow
                    && (!capNeed || fifoInReady);
  assign stallNow = evtValid && !modeBusy && !markNow && !userNow
                    && capNeed && !fifoInReady;

  always_comb
  begin
    if (coreMode.halted)
    begin
      statusNext = rtp_pkg::ST_HALTED;
    end
    else if (coreMode.stopped)
    begin
      statusNext = rtp_pkg::ST_STOPPED;
    end
    else if (coreMode.emuExc)
    begin
      statusNext = rtp_pkg::ST_EMU_EXC;
    end
    else if (coreMode.exc)
    begin
      statusNext = rtp_pkg::ST_EXCEPTION;
    end
    else if (markNow)
    begin
      statusNext = rtp_pkg::markerOf(fifoHead.byteCntM1);
    end
    else if (userNow)
    begin
      statusNext = rtp_pkg::ST_USER_ENTRY;
    end
    else if (evtOk)
    begin
      statusNext = evCode(evt.kind);
    end
    else
    begin
      statusNext = rtp_pkg::ST_CONTINUE;
    end
  end

  // User-mode entry shown in the first slot after the causing instruction not taken by a mode or marker code
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      userPend_q <= 1'b0;
    end
    else if (tick)
    begin
      if (evtOk && evt.kind == rtp_pkg::EV_USER_ENTRY)
      begin
        userPend_q <= 1'b1;
      end
      else if (userNow)
      begin
        userPend_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      evtTaken  <= 1'b0;
      coreStall <= 1'b0;
    end
    else
    begin
      evtTaken <= tick && evtOk;
      if (tick)
      begin
        coreStall <= stallNow;
      end
    end
  end

  rtp_fifo #(
    .WIDTH (rtp_pkg::ENTRY_BITS),
    .DEPTH (rtp_pkg::FIFO_DEPTH)
  ) u_fifo (
    .core_clk (core_clk),
    .rst      (rst),
    .inValid  (tick && evtOk && capNeed),
    .inReady  (fifoInReady),
    .inData   (fifoIn),
    .outValid (fifoOutValid),
    .outReady (tick && markNow),
    .outData  (fifoHead)
  );

  // Head leaves the buffer when its marker goes out; shifter holds it after
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      dataState_q <= rtp_pkg::DS_IDLE;
      shiftReg_q  <= '0;
      shiftLeft_q <= '0;
    end
    else if (tick)
    begin
      if (markNow)
      begin
        dataState_q <= rtp_pkg::DS_SHIFT;
        shiftReg_q  <= fifoHead.data;
        shiftLeft_q <= rtp_pkg::nibblesOf(fifoHead.byteCntM1);
      end
      else if (shiftLeft_q != 4'h0)
      begin
        shiftReg_q  <= {4'h0, shiftReg_q[rtp_pkg::DATA_BITS-1:4]};
        shiftLeft_q <= shiftLeft_q - 4'h1;
        if (shiftLeft_q == 4'h1)
        begin
          dataState_q <= rtp_pkg::DS_IDLE;
        end
      end
    end
  end

  // Output nibbles; disable wins every cycle, not only at slot edges
  always_ff @(posedge core_clk or posedge rst)
  begin
    if (rst)
    begin
      processorStatusNibble <= rtp_pkg::ST_CONTINUE;
      debugDataNibble       <= '0;
    end
    else if (traceOutputDisable)
    begin
      processorStatusNibble <= '0;
      debugDataNibble       <= '0;
    end
    else if (tick)
    begin
      processorStatusNibble <= statusNext;
      debugDataNibble       <= (shiftLeft_q != 4'h0) ? shiftReg_q[3:0] : bkptStatus;
    end
  end

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);

  reserved_codes_a: assert property (
    processorStatusNibble != 4'h2 && processorStatusNibble != 4'h6)
    else $error("reserved status code driven");

  halt_code_a: assert property (
    tick && coreMode.halted && !traceOutputDisable |=>
      processorStatusNibble == rtp_pkg::ST_HALTED ##1 processorStatusNibble == rtp_pkg::ST_HALTED)
    else $error("halted slot did not show code F");

  stop_code_a: assert property (
    tick && !coreMode.halted && coreMode.stopped && !traceOutputDisable |=>
      processorStatusNibble == rtp_pkg::ST_STOPPED)
    else $error("stopped slot did not show code E");

  emu_exc_a: assert property (
    tick && coreMode == 4'h2 && !traceOutputDisable |=>
      processorStatusNibble == rtp_pkg::ST_EMU_EXC)
    else $error("emulation exception slot did not show code D");

  exc_code_a: assert property (
    tick && coreMode == 4'h1 && !traceOutputDisable |=>
      processorStatusNibble == rtp_pkg::ST_EXCEPTION)
    else $error("exception slot did not show code C");

  trace_disable_a: assert property (
    traceOutputDisable |=> !traceOutEnable && !statusSampleClock
      && processorStatusNibble == 4'h0 && debugDataNibble == 4'h0)
    else $error("trace outputs not forced off");

  marker_before_data_a: assert property (
    tick && markNow |=> dataState_q == rtp_pkg::DS_SHIFT
      && shiftLeft_q == rtp_pkg::nibblesOf($past(fifoHead.byteCntM1)))
    else $error("marker not followed by data load");

  low_nibble_first_a: assert property (
    tick && shiftLeft_q != 4'h0 && !traceOutputDisable |=>
      debugDataNibble == $past(shiftReg_q[3:0]))
    else $error("data nibble out of order");

  stall_when_full_a: assert property (
    $rose(coreStall) |-> $past(!fifoInReady && evtValid))
    else $error("stall raised without full buffer");

  branch_code_a: assert property (
    tick && evtOk && evt.kind == rtp_pkg::EV_VARIANT_BRANCH && !traceOutputDisable |=>
      processorStatusNibble == rtp_pkg::ST_BRANCH && evtTaken)
    else $error("taken branch did not show code 5");

  exc_return_a: assert property (
    tick && evtOk && evt.kind == rtp_pkg::EV_EXC_RETURN && !traceOutputDisable |=>
      processorStatusNibble == rtp_pkg::ST_EXC_RETURN)
    else $error("exception return did not show code 7");

  marker_cover_c: cover property (tick && markNow);
  stall_cover_c: cover property ($rose(coreStall) ##[1:200] $fell(coreStall));
  write_cover_c: cover property (tick && evtOk && evt.kind == rtp_pkg::EV_DEBUG_WRITE);
  halt_cover_c: cover property (processorStatusNibble == rtp_pkg::ST_HALTED);

endmodule
`default_nettype wire

/* File: testbench/rtp_dev_model.sv */
// Development system model: samples the trace nibbles and decodes transfers.
`timescale 1ns/1ps
`default_nettype none
module rtp_dev_model (
  input wire logic       statusSampleClock,
  input wire logic [3:0] processorStatusNibble,
  input wire logic [3:0] debugDataNibble
);
  logic [3:0]  lastStatus;
  logic [3:0]  lastData;
  logic [31:0] xferQ[$];
  logic [31:0] acc;
  int          left;
  int          idx;
  int          badCodes;
  event        sampled;

  initial
  begin
    lastStatus = 4'h0;
    lastData   = 4'h0;
    acc        = 32'h0;
    left       = 0;
    idx        = 0;
    badCodes   = 0;
  end

  // Nibbles are only stable mid-slot, so sample on the rising sample clock
  always @(posedge statusSampleClock)
  begin
    lastStatus = processorStatusNibble;
    lastData   = debugDataNibble;
    // Data first: a new marker may share the slot of the last nibble
    if (left > 0)
    begin
      acc[idx*4 +: 4] = debugDataNibble;
      idx++;
      left--;
      if (left == 0)
        xferQ.push_back(acc);
    end
    if (processorStatusNibble[3:2] == 2'h2)
    begin
      left = 2 * (int'(processorStatusNibble[1:0]) + 1);
      idx  = 0;
      acc  = 32'h0;
    end
    if (processorStatusNibble == 4'h2 || processorStatusNibble == 4'h6)
      badCodes++;
    -> sampled;
  end
endmodule
`default_nettype wire

/* File: testbench/rtp_trace_port_tb.sv */
// Self-checking bench for the trace port.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) \
  begin \
    n_compared++; \
    if ((g) !== (e)) \
    begin \
      error_cnt++; \
      $display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); \
    end \
  end
module rtp_trace_port_tb;
  logic                  core_clk;
  logic                  rst;
  logic                  traceOutputDisable;
  logic                  captureEnable;
  logic [1:0]            addrBytesSel;
  logic [3:0]            bkptStatus;
  rtp_pkg::rtp_mode_type coreMode;
  logic                  evtValid;
  rtp_pkg::rtp_event_type evt;
  logic                  evtTaken;
  logic                  coreStall;
  logic                  statusSampleClock;
  logic [3:0]            processorStatusNibble;
  logic [3:0]            debugDataNibble;
  logic                  traceOutEnable;
  logic                  sawStall;
  logic [31:0]           got;
  int                    error_cnt;
  int                    n_compared;
  int                    cycleCnt;

  rtp_trace_port u_rtp_trace_port (
    .core_clk              (core_clk),
    .rst                   (rst),
    .traceOutputDisable    (traceOutputDisable),
    .captureEnable         (captureEnable),
    .addrBytesSel          (addrBytesSel),
    .bkptStatus            (bkptStatus),
    .coreMode              (coreMode),
    .evtValid              (evtValid),
    .evt                   (evt),
    .evtTaken              (evtTaken),
    .coreStall             (coreStall),
    .statusSampleClock     (statusSampleClock),
    .processorStatusNibble (processorStatusNibble),
    .debugDataNibble       (debugDataNibble),
    .traceOutEnable        (traceOutEnable)
  );

  rtp_dev_model u_rtp_dev_model (
    .statusSampleClock     (statusSampleClock),
    .processorStatusNibble (processorStatusNibble),
    .debugDataNibble       (debugDataNibble)
  );

  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end

  task automatic stop_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // Expected run is a few thousand cycles
  always @(posedge core_clk)
  begin
    cycleCnt++;
    if (cycleCnt == 20000)
    begin
      error_cnt++;
      stop_test();
    end
  end

  task automatic nextSlot();
    @(u_rtp_dev_model.sampled);
    @(negedge core_clk);
  endtask

  task automatic issue(input rtp_pkg::rtp_kind_type k, input logic [1:0] sz,
                       input logic [31:0] v);
    @(negedge core_clk);
    evtValid = 1'b1;
    evt = '{kind: k, opSize: sz, operand: v};
    do
    begin
      @(negedge core_clk);
      if (coreStall === 1'b1)
        sawStall = 1'b1;
    end
    while (evtTaken !== 1'b1);
    evtValid = 1'b0;
  endtask

  task automatic xfer(input int nBytes, input logic [31:0] v);
    logic [31:0] m;
    m = (nBytes == 4) ? 32'hFFFFFFFF : ((32'h1 << (8 * nBytes)) - 32'h1);
    nextSlot();
    `CHK(u_rtp_dev_model.lastStatus, 4'(7 + nBytes))
    repeat (2 * nBytes + 1) nextSlot();
    `CHK(u_rtp_dev_model.lastData, bkptStatus)
    `CHK(u_rtp_dev_model.xferQ.size(), 1)
    got = u_rtp_dev_model.xferQ.pop_front();
    `CHK(got, v & m)
  endtask

  task automatic t_reset();
    `CHK(processorStatusNibble, 4'h0)
    `CHK(debugDataNibble, 4'h0)
    nextSlot();
    `CHK(u_rtp_dev_model.lastStatus, 4'h0)
    nextSlot();
    `CHK(u_rtp_dev_model.lastStatus, 4'h0)
    `CHK(u_rtp_dev_model.lastData, bkptStatus)
    $display("test reset done");
  endtask

  task automatic t_codes();
    rtp_pkg::rtp_kind_type kinds[5];
    logic [3:0]            codes[5];
    kinds = '{rtp_pkg::EV_PLAIN, rtp_pkg::EV_PULSE, rtp_pkg::EV_EXC_RETURN,
              rtp_pkg::EV_BRANCH, rtp_pkg::EV_VARIANT_BRANCH};
    codes = '{4'h1, 4'h4, 4'h7, 4'h5, 4'h5};
    captureEnable = 1'b0;
    for (int i = 0; i < 5; i++)
    begin
      issue(kinds[i], 2'h0, 32'h2468ACE0);
      nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, codes[i])
      nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, 4'h0)
    end
    `CHK(u_rtp_dev_model.xferQ.size(), 0)
    issue(rtp_pkg::EV_USER_ENTRY, 2'h0, 32'h0);
    nextSlot();
    `CHK(u_rtp_dev_model.lastStatus, 4'h1)
    nextSlot();
    `CHK(u_rtp_dev_model.lastStatus, 4'h3)
    $display("test codes done");
  endtask

  task automatic t_branch();
    int nb;
    captureEnable = 1'b1;
    for (int sel = 0; sel < 4; sel++)
    begin
      addrBytesSel = 2'(sel);
      bkptStatus   = 4'(9 + sel);
      nb = (sel == 0) ? 2 : sel + 1;
      issue(rtp_pkg::EV_VARIANT_BRANCH, 2'h0, 32'h87654321 + 32'(sel));
      nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, 4'h5)
      xfer(nb, 32'h87654321 + 32'(sel));
    end
    $display("test branch done");
  endtask

  task automatic t_dwrite();
    int sizes[3];
    sizes = '{1, 2, 4};
    captureEnable = 1'b0;
    for (int sz = 0; sz < 3; sz++)
    begin
      issue(rtp_pkg::EV_DEBUG_WRITE, 2'(sz), 32'h13579BDF);
      nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, 4'h4)
      xfer(sizes[sz], 32'h13579BDF);
    end
    $display("test debug write done");
  endtask

  task automatic t_modes();
    logic [3:0] codes[4];
    codes = '{4'hC, 4'hD, 4'hE, 4'hF};
    for (int i = 0; i < 4; i++)
    begin
      @(negedge core_clk);
      coreMode = rtp_pkg::rtp_mode_type'(4'h1 << i);
      repeat (2) nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, codes[i])
      nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, codes[i])
      @(negedge core_clk);
      coreMode = '0;
      repeat (2) nextSlot();
      `CHK(u_rtp_dev_model.lastStatus, 4'h0)
    end
    $display("test modes done");
  endtask

  task automatic t_stall();
    captureEnable = 1'b1;
    addrBytesSel  = 2'h3;
    sawStall      = 1'b0;
    for (int i = 0; i < 4; i++)
      issue(rtp_pkg::EV_VARIANT_BRANCH, 2'h0, 32'hA0B0C000 + 32'(i));
    repeat (50) nextSlot();
    `CHK(sawStall, 1'b1)
    `CHK(u_rtp_dev_model.xferQ.size(), 4)
    for (int i = 0; i < 4; i++)
    begin
      got = u_rtp_dev_model.xferQ.pop_front();
      `CHK(got, 32'hA0B0C000 + 32'(i))
    end
    $display("test stall done");
  endtask

  task automatic t_disable();
    `CHK(traceOutEnable, 1'b1)
    @(negedge core_clk);
    traceOutputDisable = 1'b1;
    @(negedge core_clk);
    repeat (30)
    begin
      @(negedge core_clk);
      `CHK({statusSampleClock, traceOutEnable}, 2'h0)
      `CHK({processorStatusNibble, debugDataNibble}, 8'h0)
    end
    traceOutputDisable = 1'b0;
    `CHK(u_rtp_dev_model.badCodes, 0)
    $display("test disable done");
  endtask

  initial
  begin
    rst                = 1'b1;
    traceOutputDisable = 1'b0;
    captureEnable      = 1'b0;
    addrBytesSel       = 2'h1;
    bkptStatus         = 4'h6;
    coreMode           = '0;
    evtValid           = 1'b0;
    evt                = '0;
    sawStall           = 1'b0;
    got                = 32'h0;
    error_cnt          = 0;
    n_compared         = 0;
    cycleCnt           = 0;
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    rst = 1'b0;
    @(negedge core_clk);
    t_reset();
    t_codes();
    t_branch();
    t_dwrite();
    t_modes();
    t_stall();
    t_disable();
    stop_test();
  end
endmodule
`default_nettype wire
